/* logic/timer_pkg.sv */
package timer_pkg;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAG = 8'h0C;
    localparam logic [7:0] IDX_CNT_LOW = 8'h0E;
    localparam logic [7:0] IDX_CNT_HIGH = 8'h0F;
    localparam logic [7:0] IDX_CTRL = 8'h10;
    localparam logic [7:0] IDX_CFG = 8'h11;

    // timer_control fields
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_CLK_SRC = 1;
    localparam int unsigned CTRL_SYNC_DIS = 2;
    localparam int unsigned CTRL_OSC_EN = 3;
    localparam int unsigned CTRL_PRE_LSB = 4;
    localparam int unsigned CTRL_GATE_EN = 6;
    localparam int unsigned CTRL_GATE_INV = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // flag register and configuration register fields
    localparam int unsigned FLAG_OVF = 0;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam int unsigned CFG_OSC_LSB = 0;
    localparam int unsigned CFG_GATE_SRC = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;

    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [3:0] COMPARE_TRIGGER_MODE = 4'hB;

    // system clock periods per instruction cycle
    localparam int unsigned INSTR_CLOCKS = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OSC_INTRC_NO_CLOCK_OUTPUT_PIN = 2'h0,
        OSC_LOW_POWER = 2'h1,
        OSC_OTHER = 2'h2,
        OSC_OTHER_ALT = 2'h3
    } osc_mode_t;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'h1,
        WR_RESP = 2'h2
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } rd_state_t;

endpackage

/* logic/gated_timer.sv */
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps

module gated_timer
    import timer_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic warm_reset_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic external_count_input,
    input wire logic lp_osc_input,
    input wire logic gate_input_pin,
    input wire logic comparator_gate,
    input wire logic sleep_mode,
    input wire logic compare_event_one,
    input wire logic [3:0] compare_mode_one,
    input wire logic compare_event_two,
    input wire logic [3:0] compare_mode_two,
    output logic overflow_flag,
    output logic wake_request,
    output logic lp_osc_run
);

    function automatic logic [2:0] prescale_limit(input logic [1:0] sel);
        prescale_limit = 3'((4'h1 << sel) - 4'h1);
    endfunction

    function automatic logic is_trigger(input logic ev, input logic [3:0] mode);
        is_trigger = ev && (mode == COMPARE_TRIGGER_MODE);
    endfunction

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = ADDR_W'({idx, 2'h0});
    endfunction

    logic [7:0] ctrl_q, cfg_q, flag_q;
    logic [15:0] count_q;
    logic [2:0] pre_q;
    logic [1:0] instr_q;
    logic [2:0] ext_sync_q, gate_sync_q;
    logic ext_lvl_q, ext_prev_q, gate_lvl_q, armed_q, pending_q;

    wr_state_t wr_state_q;
    rd_state_t rd_state_q;
    logic aw_got_q, w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // control decode
    logic run, clk_src, sync_dis, osc_en, gate_en, gate_inv;
    logic [1:0] pre_sel;
    osc_mode_t osc_mode;
    assign run = ctrl_q[CTRL_RUN];
    assign clk_src = ctrl_q[CTRL_CLK_SRC];
    assign sync_dis = ctrl_q[CTRL_SYNC_DIS];
    assign osc_en = ctrl_q[CTRL_OSC_EN];
    assign pre_sel = ctrl_q[CTRL_PRE_LSB +: 2];
    assign gate_en = ctrl_q[CTRL_GATE_EN];
    assign gate_inv = ctrl_q[CTRL_GATE_INV];
    assign osc_mode = osc_mode_t'(cfg_q[CFG_OSC_LSB +: 2]);

    logic osc_allowed, use_lp, async_mode;
    assign osc_allowed = (osc_mode == OSC_INTRC_NO_CLOCK_OUTPUT_PIN) || (osc_mode == OSC_LOW_POWER);
    assign use_lp = osc_allowed && osc_en && clk_src;
    // sleep is not looked at: enabled crystal keeps running through it
    assign lp_osc_run = (osc_mode == OSC_LOW_POWER) || (osc_allowed && osc_en);
    assign async_mode = clk_src && sync_dis;

    // bus write execution happens once both halves are held
    logic do_write;
    assign do_write = (wr_state_q == WR_COLLECT) && aw_got_q && w_got_q;

    logic wr_low, wr_high, wr_ctrl, wr_cfg, wr_flag, cnt_write;
    assign wr_low = do_write && (awaddr_q == reg_addr(IDX_CNT_LOW)) && wstrb_q[0];
    assign wr_high = do_write && (awaddr_q == reg_addr(IDX_CNT_HIGH)) && wstrb_q[0];
    assign wr_ctrl = do_write && (awaddr_q == reg_addr(IDX_CTRL)) && wstrb_q[0];
    assign wr_cfg = do_write && (awaddr_q == reg_addr(IDX_CFG)) && wstrb_q[0];
    assign wr_flag = do_write && (awaddr_q == reg_addr(IDX_FLAG)) && wstrb_q[0];
    assign cnt_write = wr_low || wr_high;

    // pins: three stages, level moves once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync_q <= 3'h0;
            gate_sync_q <= 3'h0;
            ext_lvl_q <= 1'b0;
            ext_prev_q <= 1'b0;
            gate_lvl_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], use_lp ? lp_osc_input : external_count_input};
            gate_sync_q <= {gate_sync_q[1:0], gate_input_pin};
            if (ext_sync_q[1] == ext_sync_q[2]) begin
                ext_lvl_q <= ext_sync_q[2];
            end
            if (gate_sync_q[1] == gate_sync_q[2]) begin
                gate_lvl_q <= gate_sync_q[2];
            end
            ext_prev_q <= ext_lvl_q;
        end
    end

    // instruction cycle tick
    logic instr_tick;
    assign instr_tick = (instr_q == 2'(INSTR_CLOCKS - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_q <= 2'h0;
        end else begin
            instr_q <= instr_tick ? 2'h0 : instr_q + 2'h1;
        end
    end

    // falling edge must be seen before a rising edge counts
    logic ext_rise;
    assign ext_rise = ext_lvl_q && !ext_prev_q && armed_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_q <= 1'b0;
        end else if (!run || !clk_src) begin
            armed_q <= 1'b0;
        end else if (ext_prev_q && !ext_lvl_q) begin
            // a low level at enable is not enough; the edge itself must be seen
            armed_q <= 1'b1;
        end
    end

    // synchronized mode holds an edge until the next instruction tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_q <= 1'b0;
        end else if (instr_tick || !run) begin
            pending_q <= 1'b0;
        end else if (ext_rise) begin
            pending_q <= 1'b1;
        end
    end

    logic src_tick, gate_src, gate_active, count_en, inc_en, trig_hit, trig_reset;
    always_comb begin
        if (!clk_src) begin
            src_tick = instr_tick;
        end else if (sync_dis) begin
            src_tick = ext_rise;
        end else begin
            src_tick = instr_tick && (pending_q || ext_rise);
        end
    end

    assign gate_src = cfg_q[CFG_GATE_SRC] ? comparator_gate : gate_lvl_q;
    assign gate_active = gate_src ^ gate_inv;
    // only the unsynchronized counter survives sleep
    assign count_en = run && (!gate_en || gate_active) && (!sleep_mode || async_mode);
    assign inc_en = src_tick && count_en && (pre_q == prescale_limit(pre_sel));

    assign trig_hit = is_trigger(compare_event_one, compare_mode_one)
        || is_trigger(compare_event_two, compare_mode_two);
    // single-clock model: the unsynchronized path simply ignores the trigger
    assign trig_reset = trig_hit && !async_mode && !cnt_write;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 3'h0;
        end else if (cnt_write) begin
            pre_q <= 3'h0;
        end else if (src_tick && count_en) begin
            pre_q <= (pre_q == prescale_limit(pre_sel)) ? 3'h0 : pre_q + 3'h1;
        end
    end

    // count: write beats trigger, trigger beats increment
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= COUNT_RESET;
        end else if (cnt_write) begin
            if (wr_low) begin
                count_q[7:0] <= wdata_q[7:0];
            end
            if (wr_high) begin
                count_q[15:8] <= wdata_q[7:0];
            end
        end else if (trig_reset) begin
            count_q <= COUNT_RESET;
        end else if (inc_en) begin
            count_q <= count_q + 16'h0001;
        end
    end

    logic ovf_event;
    assign ovf_event = inc_en && !cnt_write && !trig_reset && (count_q == COUNT_MAX);

    // flag register: hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn || !warm_reset_n) begin
            flag_q <= FLAG_RESET;
        end else begin
            if (wr_flag) begin
                flag_q[FLAG_OVF] <= wdata_q[FLAG_OVF];
            end
            if (ovf_event) begin
                flag_q[FLAG_OVF] <= 1'b1;
            end
        end
    end
    assign overflow_flag = flag_q[FLAG_OVF];
    assign wake_request = flag_q[FLAG_OVF] && sleep_mode;

    // control survives warm reset, cleared only by power-on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            cfg_q <= CFG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata_q[7:0];
            end
            if (wr_cfg) begin
                cfg_q <= {5'h00, wdata_q[2:0]};
            end
        end
    end

    // write channel
    logic wr_mapped;
    assign wr_mapped = (awaddr_q == reg_addr(IDX_FLAG)) || (awaddr_q == reg_addr(IDX_CNT_LOW))
        || (awaddr_q == reg_addr(IDX_CNT_HIGH)) || (awaddr_q == reg_addr(IDX_CTRL))
        || (awaddr_q == reg_addr(IDX_CFG));
    assign awready = (wr_state_q == WR_COLLECT) && !aw_got_q;
    assign wready = (wr_state_q == WR_COLLECT) && !w_got_q;
    assign bvalid = (wr_state_q == WR_RESP);

    always_ff @(posedge aclk) begin
        if (!aresetn || !warm_reset_n) begin
            wr_state_q <= WR_COLLECT;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp <= RESP_OKAY;
        end else begin
            case (wr_state_q)
                WR_COLLECT: begin
                    if (awvalid && awready) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= awaddr;
                    end
                    if (wvalid && wready) begin
                        w_got_q <= 1'b1;
                        wdata_q <= wdata;
                        wstrb_q <= wstrb;
                    end
                    if (do_write) begin
                        wr_state_q <= WR_RESP;
                        bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        wr_state_q <= WR_COLLECT;
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                    end
                end
                default: begin
                    wr_state_q <= WR_COLLECT;
                end
            endcase
        end
    end

    // read channel; count bytes come straight from flops, never mid-update
    assign arready = (rd_state_q == RD_IDLE);
    assign rvalid = (rd_state_q == RD_DATA);

    always_ff @(posedge aclk) begin
        if (!aresetn || !warm_reset_n) begin
            rd_state_q <= RD_IDLE;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (arvalid) begin
                        rd_state_q <= RD_DATA;
                        rresp <= RESP_OKAY;
                        if (araddr == reg_addr(IDX_CNT_LOW)) begin
                            rdata <= {24'h000000, count_q[7:0]};
                        end else if (araddr == reg_addr(IDX_CNT_HIGH)) begin
                            rdata <= {24'h000000, count_q[15:8]};
                        end else if (araddr == reg_addr(IDX_CTRL)) begin
                            rdata <= {24'h000000, ctrl_q};
                        end else if (araddr == reg_addr(IDX_CFG)) begin
                            rdata <= {24'h000000, cfg_q};
                        end else if (araddr == reg_addr(IDX_FLAG)) begin
                            rdata <= {24'h000000, flag_q};
                        end else begin
                            rdata <= 32'h0000_0000;
                            rresp <= RESP_SLVERR;
                        end
                    end
                end
                RD_DATA: begin
                    if (rready) begin
                        rd_state_q <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_q <= RD_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !warm_reset_n);

    a_overflow_rolls: assert property (
        ovf_event |=> (count_q == COUNT_RESET) && overflow_flag
    ) else $error("overflow did not roll over and set the flag");

    a_trigger_no_flag: assert property (
        trig_reset && !overflow_flag && !wr_flag |=> !overflow_flag
    ) else $error("trigger clear set the overflow flag");

    a_trigger_clears: assert property (
        trig_hit && !async_mode && !cnt_write |=> count_q == COUNT_RESET
    ) else $error("compare trigger did not clear the count");

    a_write_wins: assert property (
        wr_low && trig_hit |=> count_q[7:0] == $past(wdata_q[7:0])
    ) else $error("trigger overrode a count write");

    a_stopped_holds: assert property (
        !run && !cnt_write && !trig_reset |=> $stable(count_q)
    ) else $error("count moved while stopped");

    a_gate_blocks: assert property (
        run && gate_en && !gate_active && !cnt_write && !trig_reset |=> $stable(count_q)
    ) else $error("count moved with the gate closed");

    a_prescale_clear: assert property (
        cnt_write |=> pre_q == 3'h0 ##1 (pre_q <= prescale_limit(pre_sel))
    ) else $error("prescaler not cleared by a count write");

    a_timer_rate: assert property (
        run && !clk_src && !gate_en && !sleep_mode && pre_sel == 2'h0 && instr_tick
            && !cnt_write && !trig_reset && count_q != COUNT_MAX
            |=> count_q == $past(count_q) + 16'h0001
    ) else $error("timer mode missed an instruction cycle");

    a_osc_ignored: assert property (
        !osc_allowed |-> !use_lp && (lp_osc_run == (osc_mode == OSC_LOW_POWER))
    ) else $error("oscillator enable honoured in a foreign mode");

    a_crystal_runs: assert property (
        osc_mode == OSC_INTRC_NO_CLOCK_OUTPUT_PIN && osc_en |-> lp_osc_run
    ) else $error("crystal stopped while enabled");

    a_control_por: assert property (
        @(posedge aclk) disable iff (1'b0) !aresetn |=> ctrl_q == CTRL_RESET
    ) else $error("control not cleared by power-on reset");

endmodule // gated_timer

/* test/compare_units_model.sv */
`timescale 1ns/1ps

module compare_units_model (
    input wire logic fire_one,
    input wire logic fire_two,
    input wire logic [3:0] mode,
    output logic compare_event_one,
    output logic [3:0] compare_mode_one,
    output logic compare_event_two,
    output logic [3:0] compare_mode_two
);
    // events pass straight through so a trigger can be aimed at one exact edge
    always_comb begin
        compare_event_one = fire_one;
        compare_event_two = fire_two;
        compare_mode_one = mode;
        compare_mode_two = mode;
    end
endmodule // compare_units_model

/* test/tb.sv */
`timescale 1ns/1ps

module tb;
    import timer_pkg::*;
    logic aclk, aresetn, warm_reset_n;
    logic [11:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb, cmp_mode, mode_one, mode_two;
    logic [1:0] bresp, rresp, resp;
    logic ext_in, lp_in, gate_pin, cmp_gate, sleep, fire_one, fire_two;
    logic ev_one, ev_two, ovf, wake, osc_run;
    logic [15:0] keep;
    int errors, n_checks;
    logic [5:0] g_src = 6'b001100;
    logic [5:0] g_pin = 6'b100000;
    logic [5:0] g_exp = 6'b010110;
    logic [7:0] g_ctl [6] = '{8'h41, 8'hC1, 8'h41, 8'hC1, 8'h01, 8'h40};

    gated_timer gated_timer_i (.aclk(aclk), .aresetn(aresetn), .warm_reset_n(warm_reset_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .external_count_input(ext_in), .lp_osc_input(lp_in),
        .gate_input_pin(gate_pin), .comparator_gate(cmp_gate), .sleep_mode(sleep),
        .compare_event_one(ev_one), .compare_mode_one(mode_one),
        .compare_event_two(ev_two), .compare_mode_two(mode_two),
        .overflow_flag(ovf), .wake_request(wake), .lp_osc_run(osc_run));

    compare_units_model compare_units_model_i (.fire_one(fire_one), .fire_two(fire_two),
        .mode(cmp_mode), .compare_event_one(ev_one), .compare_mode_one(mode_one),
        .compare_event_two(ev_two), .compare_mode_two(mode_two));

    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end

    function automatic logic [11:0] ad(logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic rng(string s, int lo, int hi, logic [31:0] g);
        n_checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            errors++;
            $display("[FAIL] %s expected %0d..%0d seen %h", s, lo, hi, g);
        end
    endtask

    // sampling at the falling edge keeps the handshake view free of edge races
    task automatic wr(logic [7:0] i, logic [7:0] d, bit fire = 0);
        bit aw, w, b, done;
        b = 0;
        done = 0;
        @(posedge aclk);
        awaddr <= ad(i);
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!b) begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
            fire_one <= fire && !done && (!awvalid || aw) && (!wvalid || w);
            if ((!awvalid || aw) && (!wvalid || w)) done = 1;
        end
        bready <= 0;
    endtask

    task automatic rd(logic [7:0] i);
        bit ar, r;
        r = 0;
        @(posedge aclk);
        araddr <= ad(i);
        arvalid <= 1;
        rready <= 1;
        while (!r) begin
            @(negedge aclk);
            ar = arvalid && arready;
            r = rvalid;
            v = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 0;
        end
        rready <= 0;
    endtask

    task automatic rck(string s, logic [7:0] i, logic [31:0] e);
        rd(i);
        chk(s, e, v);
    endtask

    // no snapshot between the byte reads, so only call this with the counter stopped
    task automatic rdc;
        logic [7:0] lo;
        rd(IDX_CNT_LOW);
        lo = v[7:0];
        rd(IDX_CNT_HIGH);
        v = {16'h0, v[7:0], lo};
    endtask

    task automatic setcnt(logic [15:0] c);
        wr(IDX_CNT_LOW, c[7:0]);
        wr(IDX_CNT_HIGH, c[15:8]);
    endtask

    task automatic pulses(bit lp, int n);
        repeat (n) begin
            @(posedge aclk);
            if (lp) lp_in <= 1;
            else ext_in <= 1;
            repeat (12) @(posedge aclk);
            if (lp) lp_in <= 0;
            else ext_in <= 0;
            repeat (11) @(posedge aclk);
        end
        repeat (16) @(posedge aclk);
    endtask

    task automatic trig(int u, logic [3:0] m);
        @(posedge aclk);
        cmp_mode <= m;
        @(posedge aclk);
        if (u == 1) fire_two <= 1;
        else fire_one <= 1;
        @(posedge aclk);
        fire_one <= 0;
        fire_two <= 0;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        tally_and_finish;
    end

    initial begin
        {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
        {ext_in, lp_in, gate_pin, cmp_gate, sleep, fire_one, fire_two} = '0;
        cmp_mode = COMPARE_TRIGGER_MODE;
        aresetn = 0;
        warm_reset_n = 1;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rck("ctrl reset", IDX_CTRL, {24'h0, CTRL_RESET});
        rck("flag reset", IDX_FLAG, {24'h0, FLAG_RESET});
        rd(8'h40);
        chk("unmapped rdata", 0, v);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(8'h40, 8'hFF);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        for (int p = 0; p < 4; p++) begin
            setcnt(16'h0000);
            wr(IDX_CTRL, 8'(p << 4) | 8'h01);
            repeat (256) @(posedge aclk);
            wr(IDX_CTRL, 8'(p << 4));
            rdc;
            rng("prescaled count", (64 >> p) - 1, (64 >> p) + 2, v);
        end
        rck("ctrl rw", IDX_CTRL, 32'h30);
        for (int k = 0; k < 6; k++) begin
            gate_pin <= g_pin[k];
            cmp_gate <= g_src[k];
            wr(IDX_CFG, {5'h0, g_src[k], 2'b00});
            setcnt(16'h0000);
            wr(IDX_CTRL, g_ctl[k]);
            repeat (64) @(posedge aclk);
            wr(IDX_CTRL, g_ctl[k] & 8'hFE);
            rdc;
            if (g_exp[k]) rng("gated count", 15, 18, v);
            else chk("gated count", 0, v);
        end
        wr(IDX_CFG, 8'h00);
        setcnt(16'hFFFE);
        wr(IDX_CTRL, 8'h01);
        repeat (40) @(posedge aclk);
        wr(IDX_CTRL, 8'h00);
        rdc;
        rng("rollover count", 7, 11, v);
        chk("overflow flag", 1, ovf);
        wr(IDX_FLAG, 8'h00);
        rck("flag cleared", IDX_FLAG, 0);
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < 2; k++) begin
                setcnt(16'h1234);
                trig(u, k ? 4'h5 : COMPARE_TRIGGER_MODE);
                rdc;
                chk("trigger count", k ? 16'h1234 : 0, v);
                chk("trigger flag", 0, ovf);
            end
        end
        cmp_mode <= COMPARE_TRIGGER_MODE;
        setcnt(16'h1234);
        wr(IDX_CNT_LOW, 8'h56, 1);
        rck("write beats trigger", IDX_CNT_LOW, 32'h56);
        setcnt(16'h0000);
        wr(IDX_CTRL, 8'h03);
        pulses(0, 5);
        wr(IDX_CTRL, 8'h02);
        rdc;
        chk("sync ext count", 4, v);
        setcnt(16'hFFFE);
        wr(IDX_CTRL, 8'h07);
        sleep <= 1;
        pulses(0, 5);
        chk("wake in sleep", 1, wake);
        sleep <= 0;
        wr(IDX_CTRL, 8'h06);
        rdc;
        chk("async count", 16'h0002, v);
        keep = v[15:0];
        wr(IDX_CTRL, 8'h08);
        chk("osc run idle", 1, osc_run);
        sleep <= 1;
        @(posedge aclk);
        chk("osc run sleep", 1, osc_run);
        sleep <= 0;
        wr(IDX_CFG, 8'h02);
        chk("osc ignored", 0, osc_run);
        wr(IDX_CFG, 8'h03);
        chk("osc ignored alt", 0, osc_run);
        wr(IDX_CFG, 8'h01);
        wr(IDX_CTRL, 8'h0A);
        @(posedge aclk);
        warm_reset_n <= 0;
        repeat (2) @(posedge aclk);
        warm_reset_n <= 1;
        rck("ctrl kept", IDX_CTRL, 32'h0A);
        rck("flag warm", IDX_FLAG, 0);
        rdc;
        chk("count kept", {16'h0, keep}, v);
        setcnt(16'h0000);
        wr(IDX_CTRL, 8'h0B);
        pulses(1, 5);
        wr(IDX_CTRL, 8'h0A);
        rdc;
        rng("crystal count", 4, 5, v);
        tally_and_finish;
    end
endmodule // tb
